// ---- ssc_params.svh ----
// Register indices, field positions, reset values and counts of the serial channel
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

// Register indices; byte address is four times the index
`define SSC_IDX_MODE 16'hFFA0
`define SSC_IDX_CSR 16'hFFA1
`define SSC_IDX_DATA_HI 16'hFFA2
`define SSC_IDX_DATA_LO 16'hFFA3
`define SSC_IDX_IRQ_STS 16'hFFA4
`define SSC_IDX_IRQ_MSK 16'hFFA5

// Reset values
`define SSC_MODE_RST 8'h00
`define SSC_CSR_FIXED 8'h80
`define SSC_DATA_RST 16'h0000

// Mode and clock control fields
`define SSC_OPM_HI 7
`define SSC_OPM_LO 6
`define SSC_SRC_BIT 3
`define SSC_RATIO_HI 2
`define SSC_RATIO_LO 0

// Operation mode codes
`define SSC_OPM_8BIT 2'h0
`define SSC_OPM_16BIT 2'h1
`define SSC_OPM_CONT 2'h2

// Control and status fields
`define SSC_CSR_SOL 6
`define SSC_CSR_OVR 5
`define SSC_CSR_RSV1 1
`define SSC_CSR_START 0

// Interrupt status and mask fields
`define SSC_IRQ_DONE 0
`define SSC_IRQ_OVR 1
`define SSC_IRQ_W 2

// Word lengths in serial clock cycles
`define SSC_LEN_8 5'h08
`define SSC_LEN_16 5'h10

// Half periods in system clocks for ratio codes 0 to 7
`define SSC_HALF_0 10'h200
`define SSC_HALF_1 10'h080
`define SSC_HALF_2 10'h020
`define SSC_HALF_3 10'h010
`define SSC_HALF_4 10'h008
`define SSC_HALF_5 10'h004
`define SSC_HALF_6 10'h002
`define SSC_HALF_7 10'h001

`endif

// ---- ssc_pkg.sv ----
// Types shared by the serial channel modules
package ssc_pkg;
	typedef enum logic {
		st_idle,
		st_shift
	} ssc_state_e;
	typedef logic [2:0] ssc_ratio_t;
endpackage

// ---- ssc_clk_if.sv ----
// Link between the channel core and its prescaler clock generator
interface ssc_clk_if;
	logic run;
	ssc_pkg::ssc_ratio_t ratio;
	logic sck;
	logic fall;
	logic rise;
	modport gen (
		input run,
		input ratio,
		output sck,
		output fall,
		output rise
	);
	modport core (
		output run,
		output ratio,
		input sck,
		input fall,
		input rise
	);
endinterface

// ---- ssc_clkgen.sv ----
// Prescaler that divides the system clock into the internal serial clock
`include "ssc_params.svh"

module ssc_clkgen (
	input wire logic pclk,
	input wire logic presetn,
	ssc_clk_if.gen cif
);
	logic [9:0] cnt_q;
	logic [9:0] cnt_d;
	logic sck_q;
	logic sck_d;
	logic [9:0] half;
	logic fall_c;
	logic rise_c;

	// Half period per ratio code, division by 1024 down to 2
	always_comb begin
		case (cif.ratio)
			3'h0: half = `SSC_HALF_0;
			3'h1: half = `SSC_HALF_1;
			3'h2: half = `SSC_HALF_2;
			3'h3: half = `SSC_HALF_3;
			3'h4: half = `SSC_HALF_4;
			3'h5: half = `SSC_HALF_5;
			3'h6: half = `SSC_HALF_6;
			default: half = `SSC_HALF_7;
		endcase
	end

	// Clock idles high and restarts from a full half period, so the first edge is always a fall
	always_comb begin
		cnt_d = cnt_q;
		sck_d = sck_q;
		fall_c = 1'b0;
		rise_c = 1'b0;
		if (!cif.run) begin
			cnt_d = 10'h000;
			sck_d = 1'b1;
		end else if (cnt_q == half - 10'h001) begin
			cnt_d = 10'h000;
			sck_d = ~sck_q;
			fall_c = sck_q;
			rise_c = ~sck_q;
		end else begin
			cnt_d = cnt_q + 10'h001;
		end
	end

	// Counter and clock level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 10'h000;
			sck_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			sck_q <= sck_d;
		end
	end

	// Edge pulses coincide with the clock flip-flop changing
	assign cif.sck = sck_q;
	assign cif.fall = fall_c;
	assign cif.rise = rise_c;
endmodule // ssc_clkgen

// ---- ssc_channel.sv ----
// Synchronous serial channel one: APB registers, shifter, clock selection and interrupt
// Function
// - Reset loads the mode and clock control register with zero, 8-bit mode at the slowest ratio.
// - A write to the mode and clock control register during a transfer aborts it.
// - Mode field 00 selects 8-bit transfer, 01 16-bit transfer and 10 continuous clock output.
// - In continuous clock mode the data pins take no part in transfers and belong to the port.
// - Bits five and four of the mode register store what is written and read it back.
// - Clock source bit zero takes the clock from the prescaler and drives it on the clock pin.
// - Clock source bit one makes the clock pin an input and shifts on the external clock.
// - Ratio codes 000 to 111 divide the system clock by 1024, 256, 64, 32, 16, 8, 4 and 2.
// - Every finished transfer of the selected length raises an interrupt request.
// - Reset loads the control and status register with only its top bit set.
// - The channel has a two-way clock pin, a receive data input and a transmit data output.
// - Words go out LSB first, each bit driven from one falling clock edge to the next.
// - Each received bit is sampled on the rising clock edge.
// - Writing one to the start flag starts a transfer; it reads one until completion.
// - With external clock, a clock pulse after completion sets the overrun flag, cleared by 0 after a read of 1.
//
// Our own choice: the APB register port.
`include "ssc_params.svh"

module ssc_channel #(
	parameter int ADDR_W = 18
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe,
	input wire logic si_i,
	output logic so_o,
	output logic so_oe,
	output logic irq
);
	localparam int IDX_W = ADDR_W - 2;

	ssc_clk_if clk_if ();

	// Prescaler clock generator
	ssc_clkgen u_clkgen (
		.pclk(pclk),
		.presetn(presetn),
		.cif(clk_if.gen)
	);

	ssc_pkg::ssc_state_e state_q;
	ssc_pkg::ssc_state_e state_d;
	logic [7:0] mode_q;
	logic [7:0] mode_d;
	logic rsv1_q;
	logic rsv1_d;
	logic so_q;
	logic so_d;
	logic ovr_q;
	logic ovr_d;
	logic ovr_seen_q;
	logic ovr_seen_d;
	logic done_once_q;
	logic done_once_d;
	logic [15:0] shreg_q;
	logic [15:0] shreg_d;
	logic [4:0] bit_cnt_q;
	logic [4:0] bit_cnt_d;
	logic [`SSC_IRQ_W-1:0] ist_q;
	logic [`SSC_IRQ_W-1:0] ist_d;
	logic [`SSC_IRQ_W-1:0] imsk_q;
	logic [`SSC_IRQ_W-1:0] imsk_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic sck_prev_q;

	logic [IDX_W-1:0] idx;
	logic aligned;
	logic hit_mode;
	logic hit_csr;
	logic hit_hi;
	logic hit_lo;
	logic hit_sts;
	logic hit_msk;
	logic hit_any;
	logic wr;
	logic rd;
	logic setup;
	logic [1:0] opm;
	logic ext_clk;
	logic cont_mode;
	logic xfer_mode;
	logic wide;
	logic [4:0] len;
	logic fall;
	logic rise;
	logic ev_done;
	logic ev_ovr;
	logic [7:0] rd_csr;
	logic [7:0] rd_byte;
	logic [`SSC_IRQ_W-1:0] ist_clr;

	// Address decode; the index sits in the word address
	assign idx = paddr[ADDR_W-1:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign hit_mode = aligned && (idx == IDX_W'(`SSC_IDX_MODE));
	assign hit_csr = aligned && (idx == IDX_W'(`SSC_IDX_CSR));
	assign hit_hi = aligned && (idx == IDX_W'(`SSC_IDX_DATA_HI));
	assign hit_lo = aligned && (idx == IDX_W'(`SSC_IDX_DATA_LO));
	assign hit_sts = aligned && (idx == IDX_W'(`SSC_IDX_IRQ_STS));
	assign hit_msk = aligned && (idx == IDX_W'(`SSC_IDX_IRQ_MSK));
	assign hit_any = hit_mode | hit_csr | hit_hi | hit_lo | hit_sts | hit_msk;

	// APB phases; the slave never inserts wait states
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit_any;
	assign prdata = prdata_q;

	// Mode decode
	assign opm = {mode_q[`SSC_OPM_HI], mode_q[`SSC_OPM_LO]};
	assign ext_clk = mode_q[`SSC_SRC_BIT];
	assign cont_mode = (opm == `SSC_OPM_CONT);
	assign xfer_mode = (opm == `SSC_OPM_8BIT) | (opm == `SSC_OPM_16BIT);
	assign wide = (opm == `SSC_OPM_16BIT);
	assign len = wide ? `SSC_LEN_16 : `SSC_LEN_8;

	// Prescaler runs only while its clock is needed, so each transfer starts on a clean period
	assign clk_if.run = ~ext_clk & ((state_q == ssc_pkg::st_shift) | cont_mode);
	assign clk_if.ratio = mode_q[`SSC_RATIO_HI:`SSC_RATIO_LO];

	// Serial clock edges from the prescaler or from the pin
	assign fall = ext_clk ? (sck_prev_q & ~sck_i) : clk_if.fall;
	assign rise = ext_clk ? (~sck_prev_q & sck_i) : clk_if.rise;

	// Pins
	assign sck_o = clk_if.sck;
	assign sck_oe = ~ext_clk;
	assign so_o = so_q;
	assign so_oe = ~cont_mode;

	// Completion and overrun events; a pulse only counts after a finished word
	assign ev_done = (state_q == ssc_pkg::st_shift) & rise & (bit_cnt_q + 5'h01 == len);
	assign ev_ovr = ext_clk & xfer_mode & (state_q == ssc_pkg::st_idle) & done_once_q & fall;

	// Status byte as seen by software
	always_comb begin
		rd_csr = `SSC_CSR_FIXED;
		rd_csr[`SSC_CSR_SOL] = so_q;
		rd_csr[`SSC_CSR_OVR] = ovr_q;
		rd_csr[`SSC_CSR_RSV1] = rsv1_q;
		rd_csr[`SSC_CSR_START] = (state_q == ssc_pkg::st_shift);
	end

	// Read data mux, captured in the setup phase
	always_comb begin
		rd_byte = 8'h00;
		if (hit_mode) begin
			rd_byte = mode_q;
		end else if (hit_csr) begin
			rd_byte = rd_csr;
		end else if (hit_hi) begin
			rd_byte = shreg_q[15:8];
		end else if (hit_lo) begin
			rd_byte = shreg_q[7:0];
		end else if (hit_sts) begin
			rd_byte = {{(8 - `SSC_IRQ_W){1'b0}}, ist_q};
		end else if (hit_msk) begin
			rd_byte = {{(8 - `SSC_IRQ_W){1'b0}}, imsk_q};
		end
		prdata_d = setup ? {24'h000000, rd_byte} : prdata_q;
	end

	// Interrupt status: write one to clear, a new event in the same cycle wins
	assign ist_clr = (wr & hit_sts) ? pwdata[`SSC_IRQ_W-1:0] : {`SSC_IRQ_W{1'b0}};
	always_comb begin
		ist_d = ist_q & ~ist_clr;
		ist_d[`SSC_IRQ_DONE] = ist_d[`SSC_IRQ_DONE] | ev_done;
		ist_d[`SSC_IRQ_OVR] = ist_d[`SSC_IRQ_OVR] | ev_ovr;
		imsk_d = (wr & hit_msk) ? pwdata[`SSC_IRQ_W-1:0] : imsk_q;
	end

	// One level output; masking hides a pending event without clearing it
	assign irq = |(ist_q & imsk_q);

	// Transfer engine and register writes
	always_comb begin
		// Hold everything unless an event below changes it
		state_d = state_q;
		mode_d = mode_q;
		rsv1_d = rsv1_q;
		so_d = so_q;
		ovr_d = ovr_q;
		ovr_seen_d = ovr_seen_q;
		done_once_d = done_once_q;
		shreg_d = shreg_q;
		bit_cnt_d = bit_cnt_q;

		// Shifting: drive on the fall, sample on the rise
		if (state_q == ssc_pkg::st_shift) begin
			if (fall) begin
				so_d = shreg_q[0];
			end
			if (rise) begin
				if (wide) begin
					shreg_d = {si_i, shreg_q[15:1]};
				end else begin
					shreg_d[7:0] = {si_i, shreg_q[7:1]};
				end
				bit_cnt_d = bit_cnt_q + 5'h01;
				if (ev_done) begin
					state_d = ssc_pkg::st_idle;
					done_once_d = 1'b1;
				end
			end
		end

		// Mode register write stops a transfer that is running
		if (wr & hit_mode) begin
			mode_d = pwdata[7:0];
			state_d = ssc_pkg::st_idle;
			bit_cnt_d = 5'h00;
		end

		// Control and status write
		if (wr & hit_csr) begin
			rsv1_d = pwdata[`SSC_CSR_RSV1];
			if (state_q == ssc_pkg::st_idle) begin
				so_d = pwdata[`SSC_CSR_SOL];
			end
			if (!pwdata[`SSC_CSR_OVR] && ovr_seen_q) begin
				ovr_d = 1'b0;
				ovr_seen_d = 1'b0;
			end
			// Writing zero to the start flag does nothing; mode 11 and clock mode never start
			if (pwdata[`SSC_CSR_START] && xfer_mode && (state_q == ssc_pkg::st_idle)) begin
				state_d = ssc_pkg::st_shift;
				bit_cnt_d = 5'h00;
				done_once_d = 1'b0;
			end
		end

		// Data byte writes; contents are not protected during a transfer
		if (wr & hit_hi) begin
			shreg_d[15:8] = pwdata[7:0];
		end
		if (wr & hit_lo) begin
			shreg_d[7:0] = pwdata[7:0];
		end

		// Arm the overrun clear once software has seen the flag set
		if (rd & hit_csr & ovr_q) begin
			ovr_seen_d = 1'b1;
		end

		// Overrun set wins over a clear in the same cycle
		if (ev_ovr) begin
			ovr_d = 1'b1;
		end
	end

	// Register all state except the pin history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ssc_pkg::st_idle;
			mode_q <= `SSC_MODE_RST;
			rsv1_q <= 1'b0;
			so_q <= 1'b0;
			ovr_q <= 1'b0;
			ovr_seen_q <= 1'b0;
			done_once_q <= 1'b0;
			shreg_q <= `SSC_DATA_RST;
			bit_cnt_q <= 5'h00;
			ist_q <= {`SSC_IRQ_W{1'b0}};
			imsk_q <= {`SSC_IRQ_W{1'b0}};
			prdata_q <= 32'h00000000;
		end else begin
			state_q <= state_d;
			mode_q <= mode_d;
			rsv1_q <= rsv1_d;
			so_q <= so_d;
			ovr_q <= ovr_d;
			ovr_seen_q <= ovr_seen_d;
			done_once_q <= done_once_d;
			shreg_q <= shreg_d;
			bit_cnt_q <= bit_cnt_d;
			ist_q <= ist_d;
			imsk_q <= imsk_d;
			prdata_q <= prdata_d;
		end
	end

	// Pin history resets to the idle high level, so leaving reset shows no false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_prev_q <= 1'b1;
		end else begin
			sck_prev_q <= sck_i;
		end
	end
endmodule // ssc_channel

// ---- ssc_properties.sv ----
// Concurrent checks on the serial channel ports
`include "ssc_params.svh"
module ssc_properties #(
	parameter int ADDR_W = 18
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic sck_o,
	input wire logic sck_oe,
	input wire logic so_o,
	input wire logic so_oe,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase and register index
	wire logic acc = psel && penable;
	wire logic [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
	sequence s_mode_wr;
		acc && pwrite && paddr[1:0] == 2'h0 && idx == `SSC_IDX_MODE;
	endsequence
	sequence s_csr_rd;
		psel && !penable && !pwrite && idx == `SSC_IDX_CSR ##1 acc;
	endsequence
	chk_src_pin: assert property (s_mode_wr |=> sck_oe == !$past(pwdata[3]))
		else $error("clock pin direction wrong");
	chk_port_handover: assert property (s_mode_wr |=> so_oe == ($past(pwdata[7:6]) != 2'h2))
		else $error("data pin ownership wrong");
	chk_tx_hold: assert property ($rose(sck_o) && sck_oe && so_oe |-> $stable(so_o))
		else $error("data out moved on rising clock");
	chk_ready_now: assert property (acc |-> pready)
		else $error("access not answered");
	chk_miss_err: assert property (acc |-> pslverr ==
		(paddr[1:0] != 2'h0 || !(idx inside {[`SSC_IDX_MODE:`SSC_IDX_IRQ_MSK]})))
		else $error("error response wrong");
	chk_rd_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
		else $error("read upper bits not zero");
	chk_csr_top: assert property (s_csr_rd |-> prdata[7])
		else $error("status top bit not set");
	chk_irq_masked: assert property (acc && pwrite && idx == `SSC_IDX_IRQ_MSK && pwdata[1:0] == 2'h0 |=> !irq)
		else $error("masked interrupt seen");
endmodule // ssc_properties

// ---- ssc_peer.sv ----
// Far-side serial device: returns a word LSB first and can supply the clock
module ssc_peer (
	input wire logic pclk,
	input wire logic sck,
	input wire logic so,
	output logic si,
	output logic sck_drv
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] tx = 16'h0000;
	logic [15:0] rx = 16'h0000;
	initial begin
		si = 1'h0;
		sck_drv = 1'h1;
	end
	// Next bit on each fall; the ring keeps the idle line changing
	always @(negedge sck) begin
		si <= tx[0];
		tx <= {tx[0], tx[15:1]};
	end
	// Device bits taken on each rise
	always @(posedge sck) rx <= {so, rx[15:1]};
	task load(input logic [15:0] w);
		tx = w;
	endtask
	// External clock pulses, line pulled high between them
	task pulses(input int n);
		repeat (n) begin
			repeat (4) @(posedge pclk);
			sck_drv <= 1'h0;
			repeat (4) @(posedge pclk);
			sck_drv <= 1'h1;
		end
	endtask
endmodule // ssc_peer

// ---- ssc_channel_tb.sv ----
// Self-checking bench for the serial channel
`include "ssc_params.svh"
module ssc_channel_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [17:0] paddr = 18'h00000;
	logic [31:0] pwdata = 32'h00000000;
	logic pready, pslverr, sck_o, sck_oe, so_o, so_oe, irq, si, sck_drv, err;
	logic [31:0] prdata, r;
	logic [15:0] seed = 16'h0F2B;
	int bad_count = 0;
	int total_checks = 0;
	int lowc = 0;
	int m_sts = 0;
	int dv[8] = '{1024, 256, 64, 32, 16, 8, 4, 2};
	wire logic sck_pin = sck_oe ? sck_o : sck_drv;
	ssc_channel ssc_channel_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .sck_i(sck_pin), .sck_o, .sck_oe, .si_i(si), .so_o, .so_oe, .irq);
	ssc_peer ssc_peer_i (.pclk, .sck(sck_pin), .so(so_o), .si, .sck_drv);
	// 250 MHz system clock
	initial forever #2 pclk = ~pclk;
	// Low phases of the driven clock give the ratio
	always @(posedge pclk) if (sck_oe && !sck_o) lowc++;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		r = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// One word each way; the model predicts both words and the status
	task automatic xfer(input logic [7:0] mode, input int n);
		logic [15:0] w;
		logic [15:0] p;
		int len;
		w = seed;
		p = lfsr(seed);
		seed = lfsr(p);
		len = mode[6] ? 16 : 8;
		apb(1'h1, `SSC_IDX_MODE, mode);
		apb(1'h1, `SSC_IDX_DATA_HI, w[15:8]);
		apb(1'h1, `SSC_IDX_DATA_LO, w[7:0]);
		ssc_peer_i.load(p);
		apb(1'h1, `SSC_IDX_CSR, 8'h01);
		apb(1'h0, `SSC_IDX_CSR, 8'h00);
		chk("busy", 1, r[0]);
		if (mode[3]) ssc_peer_i.pulses(n);
		for (int i = 0; i < 20000 && r[0] === 1'h1; i++) apb(1'h0, `SSC_IDX_CSR, 8'h00);
		chk("done", 0, r[0]);
		m_sts = m_sts | 1;
		chk("sent", w & ((1 << len) - 1), ssc_peer_i.rx >> (16 - len));
		apb(1'h0, `SSC_IDX_DATA_LO, 8'h00);
		chk("rx lo", p[7:0], r);
		apb(1'h0, `SSC_IDX_DATA_HI, 8'h00);
		if (len == 16) chk("rx hi", p[15:8], r);
		apb(1'h0, `SSC_IDX_IRQ_STS, 8'h00);
		chk("status", m_sts, r);
		chk("irq", 1, irq);
		apb(1'h1, `SSC_IDX_IRQ_STS, 8'h01);
		m_sts = m_sts & 2;
		@(posedge pclk);
		chk("irq clear", 0, irq);
	endtask
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Main sequence; software never writes the reserved mode code
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			apb(1'h0, 16'(`SSC_IDX_MODE + i), 8'h00);
			chk("reset value", i == 1 ? 8'h80 : 8'h00, r);
		end
		apb(1'h1, `SSC_IDX_MODE, seed[7:0] & 8'h3F);
		apb(1'h0, `SSC_IDX_MODE, 8'h00);
		chk("mode back", seed[7:0] & 8'h3F, r);
		apb(1'h0, 16'hFFA6, 8'h00);
		chk("miss err", 1, err);
		chk("miss data", 0, r);
		apb(1'h1, `SSC_IDX_IRQ_MSK, 8'h03);
		for (int k = 0; k < 8; k++) begin
			lowc = 0;
			xfer({5'h00, k[2:0]}, 0);
			chk("low span", 8 * dv[k] / 2, lowc);
		end
		lowc = 0;
		xfer(8'h47, 0);
		chk("low span 16", 16, lowc);
		// Mode write in mid-transfer
		apb(1'h1, `SSC_IDX_MODE, 8'h00);
		apb(1'h1, `SSC_IDX_CSR, 8'h01);
		repeat (50) @(posedge pclk);
		apb(1'h1, `SSC_IDX_MODE, 8'h00);
		apb(1'h0, `SSC_IDX_CSR, 8'h00);
		chk("abort busy", 0, r[0]);
		apb(1'h0, `SSC_IDX_IRQ_STS, 8'h00);
		chk("abort status", m_sts, r);
		// Continuous clock output
		apb(1'h1, `SSC_IDX_MODE, 8'h87);
		lowc = 0;
		apb(1'h1, `SSC_IDX_CSR, 8'h01);
		repeat (20) @(posedge pclk);
		chk("port handed over", 0, so_oe);
		chk("clock runs", 1, lowc > 5);
		apb(1'h0, `SSC_IDX_CSR, 8'h00);
		chk("no start", 0, r[0]);
		// External clock, then one stray pulse
		xfer(8'h48, 16);
		chk("clock pin input", 0, sck_oe);
		ssc_peer_i.pulses(1);
		repeat (4) @(posedge pclk);
		m_sts = m_sts | 2;
		apb(1'h0, `SSC_IDX_CSR, 8'h00);
		chk("overrun", 1, r[5]);
		apb(1'h1, `SSC_IDX_CSR, 8'h00);
		apb(1'h0, `SSC_IDX_CSR, 8'h00);
		chk("overrun clear", 0, r[5]);
		apb(1'h0, `SSC_IDX_IRQ_STS, 8'h00);
		chk("status overrun", m_sts, r);
		chk("irq overrun", 1, irq);
		// Masking hides the pending overrun from the interrupt line
		apb(1'h1, `SSC_IDX_IRQ_MSK, 8'h00);
		@(posedge pclk);
		chk("irq masked", 0, irq);
		// Level written while idle shows on the data pin and reads back
		apb(1'h1, `SSC_IDX_CSR, 8'h40);
		apb(1'h0, `SSC_IDX_CSR, 8'h00);
		chk("line level", 1, so_o);
		chk("line readback", 1, r[6]);
		complete_run();
	end
	// Cuts a hang short; the full run needs about 12000 cycles
	initial begin
		repeat (80000) @(posedge pclk);
		bad_count++;
		complete_run();
	end
endmodule // ssc_channel_tb

bind ssc_channel ssc_properties #(.ADDR_W(ADDR_W)) ssc_properties_i (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .prdata, .pslverr, .sck_o, .sck_oe, .so_o, .so_oe, .irq);
